// File: hdl/cdpr_regs.svh
// Constants of the configurable dual-port RAM: shapes, widths, path selects.
// Assumes nothing; included by the package and the design files.
`ifndef CDPR_REGS_SVH
`define CDPR_REGS_SVH

// ----------------------------------------------------------------------------
// Block geometry
// ----------------------------------------------------------------------------
`define CDPR_BLK_BITS       4096
`define CDPR_OFF_BITS       12
`define CDPR_WORD_BITS      16
`define CDPR_BLK_ADDR_BITS  11
`define CDPR_ADDR_BITS      12
`define CDPR_DATA_BITS      32
`define CDPR_LOG2_WORD      4
`define CDPR_BASE_DEPTH     12'h0100
`define CDPR_BASE_DEPTH_LOG2 8
`define CDPR_ONE_OFF        12'h0001
`define CDPR_FULL_WORD      16'hffff
`define CDPR_ZERO_WORD      16'h0000

// ----------------------------------------------------------------------------
// Shape codes
// ----------------------------------------------------------------------------
`define CDPR_SHAPE_256X16   2'h0
`define CDPR_SHAPE_512X8    2'h1
`define CDPR_SHAPE_1024X4   2'h2
`define CDPR_SHAPE_2048X2   2'h3

// ----------------------------------------------------------------------------
// Bit positions of the path-register select vector
// ----------------------------------------------------------------------------
`define CDPR_SEL_WDATA      0
`define CDPR_SEL_RDOUT      1
`define CDPR_SEL_WADDR      2
`define CDPR_SEL_WE         3
`define CDPR_SEL_RADDR      4
`define CDPR_SEL_RE         5
`define CDPR_SEL_BITS       6

`endif

// File: hdl/cdpr_pkg.sv
// Types shared by the configurable dual-port RAM.
// Assumes cdpr_regs.svh is on the include path.
`default_nettype none
`include "cdpr_regs.svh"

package cdpr_pkg;

  // How the two memory blocks are combined
  typedef enum logic [1:0] {
    CDPR_SINGLE,
    CDPR_WIDE,
    CDPR_DEEP,
    CDPR_TRUE_DP
  } cdpr_combine_e;

  typedef logic [1:0] cdpr_shape_t;

  // Output-path state of the top module
  typedef struct packed {
    logic                         rsel;
    logic                         b_lost;
    logic [`CDPR_DATA_BITS-1:0]   out_reg;
    logic [`CDPR_DATA_BITS-1:0]   rd_data;
    logic [`CDPR_WORD_BITS-1:0]   a_rd_data;
  } cdpr_top_s;

endpackage

`default_nettype wire

// File: hdl/cdpr_stage.sv
// Optional register on one path, bypassed when not selected.
// Assumes i_en already folds in the block clock enable and section tick.
`default_nettype none
`include "cdpr_regs.svh"

module cdpr_stage #(
  parameter int W = 1
) (
  // Clock and clear
  input  wire logic         i_clk,
  input  wire logic         i_clr,
  // Control
  input  wire logic         i_en,
  input  wire logic         i_sel,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] q;
  } cdpr_stage_s;

  cdpr_stage_s st_ff;
  cdpr_stage_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_en) begin
      nxt_st.q = i_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_clr) begin
    if (i_clr) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_q = i_sel ? st_ff.q : i_d;

endmodule

`default_nettype wire

// File: hdl/cdpr_mem.sv
// One 4096-bit memory block with shape-dependent word width.
// Assumes strobes already carry the clock enable and section tick.
`default_nettype none
`include "cdpr_regs.svh"

module cdpr_mem #(
  parameter logic [`CDPR_BLK_BITS-1:0] INIT = '0
) (
  // Clock, configuration reset and register clear
  input  wire logic                           i_clk,
  input  wire logic                           i_rst,
  input  wire logic                           i_clr,
  input  wire logic [1:0]                     i_shape,
  // Write port
  input  wire logic                           i_wr_stb,
  input  wire logic [`CDPR_BLK_ADDR_BITS-1:0] i_wr_addr,
  input  wire logic [`CDPR_WORD_BITS-1:0]     i_wr_data,
  // Read port
  input  wire logic                           i_rd_stb,
  input  wire logic [`CDPR_BLK_ADDR_BITS-1:0] i_rd_addr,
  output logic      [`CDPR_WORD_BITS-1:0]     o_rd_data
);

  logic [`CDPR_BLK_BITS-1:0]  arr_ff;
  logic [`CDPR_BLK_BITS-1:0]  nxt_arr;
  logic [`CDPR_WORD_BITS-1:0] nxt_rd;

  // Bit offset of a word for the chosen shape
  function automatic logic [`CDPR_OFF_BITS-1:0] bit_off(
    input logic [1:0]                     shape,
    input logic [`CDPR_BLK_ADDR_BITS-1:0] addr);
    logic [`CDPR_OFF_BITS-1:0] mask;
    mask = (`CDPR_BASE_DEPTH << shape) - `CDPR_ONE_OFF;
    return ({1'b0, addr} & mask) << (`CDPR_LOG2_WORD - shape);
  endfunction

  function automatic logic [`CDPR_WORD_BITS-1:0] word_mask(
    input logic [1:0] shape);
    return `CDPR_FULL_WORD >> (`CDPR_WORD_BITS - (`CDPR_WORD_BITS >> shape));
  endfunction

  always_comb begin
    logic [`CDPR_OFF_BITS-1:0]  woff;
    logic [`CDPR_WORD_BITS-1:0] m;
    woff    = bit_off(i_shape, i_wr_addr);
    m       = word_mask(i_shape);
    nxt_arr = arr_ff;
    if (i_wr_stb) begin
      nxt_arr = (arr_ff & ~(`CDPR_BLK_BITS'(m) << woff))
              | (`CDPR_BLK_BITS'(i_wr_data & m) << woff);
    end
    // Read sees the old word when a write lands in the same edge
    nxt_rd = `CDPR_WORD_BITS'(arr_ff >> bit_off(i_shape, i_rd_addr)) & m;
  end

  // Contents load at configuration and survive the register clears
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arr_ff <= INIT;
    end else begin
      arr_ff <= nxt_arr;
    end
  end

  always_ff @(posedge i_clk or posedge i_clr) begin
    if (i_clr) begin
      o_rd_data <= '0;
    end else if (i_rd_stb) begin
      o_rd_data <= nxt_rd;
    end
  end

endmodule

`default_nettype wire

// File: hdl/cdpr_top.sv
// Configurable dual-port RAM built from two 4096-bit memory blocks.
// Assumes all inputs are synchronous to i_ref_clk; section clocks arrive
// as one-cycle tick strobes in that domain.
`default_nettype none
`include "cdpr_regs.svh"

// Notes on behaviour
// - each block stores exactly 4096 bits
// - shapes 256x16, 512x8, 1024x4, 2048x2
// - single-port or dual-port operation selectable
// - write and read sections clocked separately
// - one clock enable i_ce shared by both sections
// - alternatively input clock pair, output clock pair
// - each path register selectable, else bypassed
// - local, global or chip reset clear registers
// - write strobe generated internally from write clock
// - preloaded contents act as lookup table
// - true dual port uses two blocks
// - two blocks side by side widen data
// - cascading adds address bit, up to 2048 words
module cdpr_top #(
  parameter logic [`CDPR_BLK_BITS-1:0] INIT_LO = '0,
  parameter logic [`CDPR_BLK_BITS-1:0] INIT_HI = '0
) (
  // Clock, reset, enable
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_ce,
  // Configuration
  input  wire logic [1:0]                  i_shape,
  input  wire logic [1:0]                  i_combine,
  input  wire logic                        i_dual_port,
  input  wire logic                        i_clk_scheme,
  input  wire logic [`CDPR_SEL_BITS-1:0]   i_reg_sel,
  input  wire logic                        i_rom_mode,
  // Register clears
  input  wire logic                        i_local_clr,
  input  wire logic                        i_global_clr,
  // Write section (port A)
  input  wire logic                        i_wr_tick,
  input  wire logic                        i_wr_en,
  input  wire logic [`CDPR_ADDR_BITS-1:0]  i_wr_addr,
  input  wire logic [`CDPR_DATA_BITS-1:0]  i_wr_data,
  input  wire logic                        i_a_rd_en,
  // Read section (port B)
  input  wire logic                        i_rd_tick,
  input  wire logic                        i_rd_en,
  input  wire logic [`CDPR_ADDR_BITS-1:0]  i_rd_addr,
  input  wire logic                        i_b_wr_en,
  input  wire logic [`CDPR_WORD_BITS-1:0]  i_b_wr_data,
  // Results
  output logic      [`CDPR_DATA_BITS-1:0]  o_rd_data,
  output logic      [`CDPR_WORD_BITS-1:0]  o_a_rd_data,
  output logic                             o_b_wr_lost
);

  // --------------------------------------------------------------------------
  // Clock scheme and clear
  // --------------------------------------------------------------------------
  cdpr_pkg::cdpr_combine_e combine;
  logic                    clr;
  logic                    single;
  logic                    rd_in_tick;
  logic                    out_tick;
  logic [`CDPR_ADDR_BITS-1:0] raddr_raw;

  assign combine = cdpr_pkg::cdpr_combine_e'(i_combine);
  assign clr     = i_rst | i_local_clr | i_global_clr;
  assign single  = ~i_dual_port;

  // Read-side inputs follow the write tick in single-port or in/out scheme
  assign rd_in_tick = (single | i_clk_scheme) ? i_wr_tick : i_rd_tick;
  assign out_tick   = single ? i_wr_tick : i_rd_tick;
  assign raddr_raw  = single ? i_wr_addr : i_rd_addr;

  // --------------------------------------------------------------------------
  // Selectable path registers
  // --------------------------------------------------------------------------
  logic                       wr_en_ce;
  logic                       rd_en_ce;
  logic [`CDPR_DATA_BITS-1:0] wdata_e;
  logic [`CDPR_ADDR_BITS-1:0] waddr_e;
  logic                       we_e;
  logic [`CDPR_ADDR_BITS-1:0] raddr_e;
  logic                       re_e;
  logic [`CDPR_WORD_BITS-1:0] bdata_e;
  logic                       bwe_e;

  assign wr_en_ce = i_ce & i_wr_tick;
  assign rd_en_ce = i_ce & rd_in_tick;

  cdpr_stage #(.W(`CDPR_DATA_BITS)) u_wdata (
    .i_clk (i_ref_clk),
    .i_clr (clr),
    .i_en  (wr_en_ce),
    .i_sel (i_reg_sel[`CDPR_SEL_WDATA]),
    .i_d   (i_wr_data),
    .o_q   (wdata_e)
  );

  cdpr_stage #(.W(`CDPR_ADDR_BITS)) u_waddr (
    .i_clk (i_ref_clk),
    .i_clr (clr),
    .i_en  (wr_en_ce),
    .i_sel (i_reg_sel[`CDPR_SEL_WADDR]),
    .i_d   (i_wr_addr),
    .o_q   (waddr_e)
  );

  cdpr_stage #(.W(1)) u_we (
    .i_clk (i_ref_clk),
    .i_clr (clr),
    .i_en  (wr_en_ce),
    .i_sel (i_reg_sel[`CDPR_SEL_WE]),
    .i_d   (i_wr_en),
    .o_q   (we_e)
  );

  cdpr_stage #(.W(`CDPR_ADDR_BITS)) u_raddr (
    .i_clk (i_ref_clk),
    .i_clr (clr),
    .i_en  (rd_en_ce),
    .i_sel (i_reg_sel[`CDPR_SEL_RADDR]),
    .i_d   (raddr_raw),
    .o_q   (raddr_e)
  );

  cdpr_stage #(.W(1)) u_re (
    .i_clk (i_ref_clk),
    .i_clr (clr),
    .i_en  (rd_en_ce),
    .i_sel (i_reg_sel[`CDPR_SEL_RE]),
    .i_d   (i_rd_en),
    .o_q   (re_e)
  );

  // Port B write data and enable share the data and enable selects
  cdpr_stage #(.W(`CDPR_WORD_BITS)) u_bdata (
    .i_clk (i_ref_clk),
    .i_clr (clr),
    .i_en  (rd_en_ce),
    .i_sel (i_reg_sel[`CDPR_SEL_WDATA]),
    .i_d   (i_b_wr_data),
    .o_q   (bdata_e)
  );

  cdpr_stage #(.W(1)) u_bwe (
    .i_clk (i_ref_clk),
    .i_clr (clr),
    .i_en  (rd_en_ce),
    .i_sel (i_reg_sel[`CDPR_SEL_WE]),
    .i_d   (i_b_wr_en),
    .o_q   (bwe_e)
  );

  // --------------------------------------------------------------------------
  // Strobes
  // --------------------------------------------------------------------------
  logic wr_go;
  logic b_req;
  logic b_go;
  logic rd_go;
  logic a_rd_go;
  logic tdp;

  assign tdp     = (combine == cdpr_pkg::CDPR_TRUE_DP);
  // Preloaded contents are never overwritten in lookup-table use
  assign wr_go   = wr_en_ce & we_e & ~i_rom_mode;
  assign b_req   = rd_en_ce & bwe_e & ~i_rom_mode & tdp & i_dual_port;
  assign b_go    = b_req & ~wr_go;
  assign rd_go   = rd_en_ce & re_e;
  assign a_rd_go = wr_en_ce & i_a_rd_en & tdp & i_dual_port;

  // --------------------------------------------------------------------------
  // Block steering
  // --------------------------------------------------------------------------
  // Address bit above the block's own depth picks the cascaded block, except in the 2048x2 shape
  function automatic logic casc_bit(
    input logic [1:0]                 shape,
    input logic [`CDPR_ADDR_BITS-1:0] addr);
    if (shape == `CDPR_SHAPE_2048X2) begin
      return 1'b0;
    end
    return addr[`CDPR_BASE_DEPTH_LOG2 + 32'(shape)];
  endfunction

  logic                           w0;
  logic                           w1;
  logic                           r0;
  logic                           r1;
  logic [`CDPR_BLK_ADDR_BITS-1:0] w0_addr;
  logic [`CDPR_BLK_ADDR_BITS-1:0] w1_addr;
  logic [`CDPR_BLK_ADDR_BITS-1:0] r0_addr;
  logic [`CDPR_BLK_ADDR_BITS-1:0] r1_addr;
  logic [`CDPR_WORD_BITS-1:0]     w0_data;
  logic [`CDPR_WORD_BITS-1:0]     w1_data;
  logic [`CDPR_WORD_BITS-1:0]     m0_data;
  logic [`CDPR_WORD_BITS-1:0]     m1_data;

  always_comb begin
    logic [`CDPR_BLK_ADDR_BITS-1:0] wa;
    logic [`CDPR_BLK_ADDR_BITS-1:0] ra;
    logic                           wsel;
    wa      = waddr_e[`CDPR_BLK_ADDR_BITS-1:0];
    ra      = raddr_e[`CDPR_BLK_ADDR_BITS-1:0];
    wsel    = casc_bit(i_shape, waddr_e);
    w0      = wr_go;
    w1      = 1'b0;
    w0_addr = wa;
    w1_addr = wa;
    w0_data = wdata_e[`CDPR_WORD_BITS-1:0];
    w1_data = wdata_e[`CDPR_DATA_BITS-1:`CDPR_WORD_BITS];
    r0      = rd_go;
    r1      = 1'b0;
    r0_addr = ra;
    r1_addr = ra;
    unique case (combine)
      cdpr_pkg::CDPR_SINGLE: begin
      end
      cdpr_pkg::CDPR_WIDE: begin
        w1 = wr_go;
        r1 = rd_go;
      end
      cdpr_pkg::CDPR_DEEP: begin
        w0      = wr_go & ~wsel;
        w1      = wr_go & wsel;
        w1_data = wdata_e[`CDPR_WORD_BITS-1:0];
        r1      = rd_go;
      end
      cdpr_pkg::CDPR_TRUE_DP: begin
        // Both blocks take every write so each port reads its own copy
        w0      = wr_go | b_go;
        w1      = wr_go | b_go;
        w0_addr = wr_go ? wa : ra;
        w1_addr = wr_go ? wa : ra;
        w0_data = wr_go ? wdata_e[`CDPR_WORD_BITS-1:0] : bdata_e;
        w1_data = w0_data;
        r0      = a_rd_go;
        r0_addr = wa;
        r1      = rd_go;
      end
    endcase
  end

  cdpr_mem #(.INIT(INIT_LO)) u_mem_lo (
    .i_clk     (i_ref_clk),
    .i_rst     (i_rst),
    .i_clr     (clr),
    .i_shape   (i_shape),
    .i_wr_stb  (w0),
    .i_wr_addr (w0_addr),
    .i_wr_data (w0_data),
    .i_rd_stb  (r0),
    .i_rd_addr (r0_addr),
    .o_rd_data (m0_data)
  );

  cdpr_mem #(.INIT(INIT_HI)) u_mem_hi (
    .i_clk     (i_ref_clk),
    .i_rst     (i_rst),
    .i_clr     (clr),
    .i_shape   (i_shape),
    .i_wr_stb  (w1),
    .i_wr_addr (w1_addr),
    .i_wr_data (w1_data),
    .i_rd_stb  (r1),
    .i_rd_addr (r1_addr),
    .o_rd_data (m1_data)
  );

  // --------------------------------------------------------------------------
  // Output path
  // --------------------------------------------------------------------------
  cdpr_pkg::cdpr_top_s        st_ff;
  cdpr_pkg::cdpr_top_s        nxt_st;
  logic [`CDPR_DATA_BITS-1:0] rd_word;
  logic [`CDPR_DATA_BITS-1:0] rd_eff;

  always_comb begin
    unique case (combine)
      cdpr_pkg::CDPR_WIDE: begin
        rd_word = {m1_data, m0_data};
      end
      cdpr_pkg::CDPR_DEEP: begin
        rd_word = {`CDPR_ZERO_WORD, st_ff.rsel ? m1_data : m0_data};
      end
      cdpr_pkg::CDPR_TRUE_DP: begin
        rd_word = {`CDPR_ZERO_WORD, m1_data};
      end
      default: begin
        rd_word = {`CDPR_ZERO_WORD, m0_data};
      end
    endcase
  end

  assign rd_eff = i_reg_sel[`CDPR_SEL_RDOUT] ? st_ff.out_reg : rd_word;

  always_comb begin
    nxt_st = st_ff;
    if (rd_go) begin
      nxt_st.rsel = casc_bit(i_shape, raddr_e);
    end
    if (i_ce & out_tick) begin
      nxt_st.out_reg = rd_word;
    end
    if (i_ce) begin
      nxt_st.rd_data   = rd_eff;
      nxt_st.a_rd_data = m0_data;
      nxt_st.b_lost    = b_req & wr_go;
    end
  end

  always_ff @(posedge i_ref_clk or posedge clr) begin
    if (clr) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rd_data   = st_ff.rd_data;
  assign o_a_rd_data = st_ff.a_rd_data;
  assign o_b_wr_lost = st_ff.b_lost;

endmodule

`default_nettype wire

// File: dv/cdpr_user.sv
// User logic model that drives the RAM's section inputs.
// Assumes a free-running clock; op is entered at a rising edge.
`default_nettype none
`include "cdpr_regs.svh"
module cdpr_user (
  // Clock
  input  wire logic                        i_clk,
  // Write section
  output var  logic                        o_wr_tick,
  output var  logic                        o_wr_en,
  output var  logic [`CDPR_ADDR_BITS-1:0]  o_wr_addr,
  output var  logic [`CDPR_DATA_BITS-1:0]  o_wr_data,
  // Read section
  output var  logic                        o_rd_tick,
  output var  logic                        o_rd_en,
  output var  logic [`CDPR_ADDR_BITS-1:0]  o_rd_addr,
  output var  logic                        o_b_wr_en,
  output var  logic [`CDPR_WORD_BITS-1:0]  o_b_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_wr_tick, o_wr_en, o_rd_tick, o_rd_en, o_b_wr_en} = 5'h00;
    o_wr_addr   = '0;
    o_wr_data   = '0;
    o_rd_addr   = '0;
    o_b_wr_data = '0;
  end
  // One request held over one edge, then one idle cycle
  task automatic op(input logic wt, input logic we, input logic rt,
                    input logic re, input logic be,
                    input logic [`CDPR_ADDR_BITS-1:0] wa,
                    input logic [`CDPR_ADDR_BITS-1:0] ra,
                    input logic [`CDPR_DATA_BITS-1:0] d);
    o_wr_tick   <= wt;
    o_wr_en     <= we;
    o_wr_addr   <= wa;
    o_wr_data   <= d;
    o_rd_tick   <= rt;
    o_rd_en     <= re;
    o_rd_addr   <= ra;
    o_b_wr_en   <= be;
    o_b_wr_data <= d[15:0];
    @(posedge i_clk);
    // Released lines carry no meaning: show the inverse
    {o_wr_tick, o_wr_en, o_rd_tick, o_rd_en, o_b_wr_en} <= 5'h00;
    o_wr_addr   <= ~wa;
    o_wr_data   <= ~d;
    o_rd_addr   <= ~ra;
    o_b_wr_data <= ~d[15:0];
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// File: dv/cdpr_top_asserts.sv
// Port checker for the configurable dual-port RAM.
// Assumes it is bound onto cdpr_top; one clock, async reset.
`default_nettype none
`include "cdpr_regs.svh"
module cdpr_top_asserts (
  // Clock and reset
  input wire logic                        i_ref_clk,
  input wire logic                        i_rst,
  // Controls
  input wire logic                        i_ce,
  input wire logic [1:0]                  i_shape,
  input wire logic [1:0]                  i_combine,
  input wire logic                        i_dual_port,
  input wire logic [`CDPR_SEL_BITS-1:0]   i_reg_sel,
  input wire logic                        i_local_clr,
  input wire logic                        i_global_clr,
  input wire logic                        i_wr_tick,
  input wire logic                        i_wr_en,
  input wire logic                        i_rd_tick,
  input wire logic                        i_b_wr_en,
  // Results
  input wire logic [`CDPR_DATA_BITS-1:0]  o_rd_data,
  input wire logic [`CDPR_WORD_BITS-1:0]  o_a_rd_data,
  input wire logic                        o_b_wr_lost
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  property p_local_clr;
    i_local_clr |-> o_rd_data == '0 && o_a_rd_data == '0;
  endproperty
  a_local_clr: assert property (p_local_clr)
    else $error("local clear left an output set");
  property p_global_clr;
    i_global_clr |-> o_rd_data == '0 && !o_b_wr_lost;
  endproperty
  a_global_clr: assert property (p_global_clr)
    else $error("global clear left an output set");
  property p_rst_rel;
    $fell(i_rst) |-> o_rd_data == '0 && o_a_rd_data == '0;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("output not zero after reset");
  property p_ce_hold;
    !i_ce && !i_local_clr && !i_global_clr |=>
      $stable(o_rd_data) && $stable(o_b_wr_lost);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("output moved with enable low");
  property p_no_tick_hold;
    (!i_wr_tick && !i_rd_tick && !i_local_clr && !i_global_clr &&
     $stable(i_shape) && $stable(i_combine) && $stable(i_reg_sel) &&
     $stable(i_dual_port))[*3] |=> $stable(o_rd_data);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold)
    else $error("read data moved without a tick");
  property p_wide_hi;
    $past(i_ce) && !$past(i_reg_sel[1]) && $past(i_combine) != 2'h1
      |-> o_rd_data[31:16] == 16'h0000;
  endproperty
  a_wide_hi: assert property (p_wide_hi)
    else $error("upper half set outside wide mode");
  property p_lost_cause;
    o_b_wr_lost |->
      $past(i_combine == 2'h3 && i_dual_port && i_wr_tick);
  endproperty
  a_lost_cause: assert property (p_lost_cause)
    else $error("lost flag without a port clash");
  property p_lost_pulse;
    o_b_wr_lost && i_ce && !(i_wr_tick && i_wr_en && i_b_wr_en)
      |=> !o_b_wr_lost;
  endproperty
  a_lost_pulse: assert property (p_lost_pulse)
    else $error("lost flag longer than one cycle");
endmodule
`default_nettype wire

// File: dv/cdpr_top_bench.sv
// Self-checking bench for the configurable dual-port RAM.
// Assumes cdpr_user and the port checker are compiled first.
`default_nettype none
`include "cdpr_regs.svh"
module cdpr_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [`CDPR_BLK_BITS-1:0] INIT_LO =
    {{(`CDPR_BLK_BITS-32){1'b0}}, 32'h5678_1234};
  logic        clk = 1'b0;
  logic        rst, ce, dual, scheme, rom, lclr, gclr;
  logic        wt, we, rt, re, be, lost, ard;
  logic [1:0]  shape, comb;
  logic [5:0]  sel;
  logic [11:0] wa, ra;
  logic [31:0] wd, rdat;
  logic [15:0] bd, ardat;
  int          errors = 0;
  int          n_tests = 0;
  always #5 clk = ~clk;
  cdpr_user u_user (.i_clk(clk), .o_wr_tick(wt), .o_wr_en(we),
    .o_wr_addr(wa), .o_wr_data(wd), .o_rd_tick(rt), .o_rd_en(re),
    .o_rd_addr(ra), .o_b_wr_en(be), .o_b_wr_data(bd));
  cdpr_top #(.INIT_LO(INIT_LO)) uut (.i_ref_clk(clk), .i_rst(rst),
    .i_ce(ce), .i_shape(shape), .i_combine(comb), .i_dual_port(dual),
    .i_clk_scheme(scheme), .i_reg_sel(sel), .i_rom_mode(rom),
    .i_local_clr(lclr), .i_global_clr(gclr), .i_wr_tick(wt),
    .i_wr_en(we), .i_wr_addr(wa), .i_wr_data(wd), .i_a_rd_en(ard),
    .i_rd_tick(rt), .i_rd_en(re), .i_rd_addr(ra), .i_b_wr_en(be),
    .i_b_wr_data(bd), .o_rd_data(rdat), .o_a_rd_data(ardat),
    .o_b_wr_lost(lost));
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_user.op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, a, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    u_user.op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, a, a, 32'h0000_0000);
    @(negedge clk) chk(rdat, e);
    @(posedge clk);
  endtask
  task automatic t_rom();
    rom <= 1'b1;
    rd(12'h000, 32'h0000_1234);
    wr(12'h000, 32'h0000_dead);
    rd(12'h000, 32'h0000_1234);
    rd(12'h001, 32'h0000_5678);
    rom <= 1'b0;
  endtask
  task automatic t_shapes();
    logic [11:0] depth;
    logic [31:0] m;
    for (int s = 0; s < 4; s++) begin
      shape <= s[1:0];
      depth = 12'h100 << s;
      m = (32'h0000_0001 << (16 >> s)) - 32'h0000_0001;
      wr(12'h001, 32'h0000_a5c3);
      wr(12'h000, 32'h0000_5a3c);
      wr(depth | 12'h002, 32'h0000_c3a5);
      rd(12'h001, 32'h0000_a5c3 & m);
      rd(12'h000, 32'h0000_5a3c & m);
      rd(12'h002, 32'h0000_c3a5 & m);
    end
  endtask
  task automatic t_combine();
    shape <= 2'h0;
    comb <= 2'h1;
    wr(12'h005, 32'h1357_9bdf);
    rd(12'h005, 32'h1357_9bdf);
    comb <= 2'h2;
    wr(12'h105, 32'h0000_1111);
    wr(12'h005, 32'h0000_2222);
    rd(12'h105, 32'h0000_1111);
    rd(12'h005, 32'h0000_2222);
    comb <= 2'h0;
  endtask
  task automatic t_regs();
    wr(12'h000, 32'h0000_0f0f);
    wr(12'h001, 32'h0000_f0f0);
    sel <= 6'h10;
    u_user.op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 12'h000, 12'h000, '0);
    rd(12'h001, 32'h0000_0f0f);
    rd(12'h000, 32'h0000_f0f0);
    sel <= 6'h00;
  endtask
  task automatic t_ce();
    wr(12'h003, 32'h0000_0003);
    ce <= 1'b0;
    wr(12'h003, 32'h0000_0bad);
    ce <= 1'b1;
    rd(12'h003, 32'h0000_0003);
    u_user.op(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 12'h000, 12'h000, '0);
    @(negedge clk) chk(rdat, 32'h0000_0003);
    @(posedge clk);
    u_user.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 12'h003, 12'h003,
              32'h0000_0777);
    @(negedge clk) chk(rdat, 32'h0000_0003);
    @(posedge clk);
    rd(12'h003, 32'h0000_0777);
  endtask
  task automatic t_ports();
    dual <= 1'b0;
    u_user.op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 12'h003, 12'h000, '0);
    @(negedge clk) chk(rdat, 32'h0000_0777);
    @(posedge clk);
    dual <= 1'b1;
    scheme <= 1'b1;
    u_user.op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 12'h000, 12'h001, '0);
    @(negedge clk) chk(rdat, 32'h0000_f0f0);
    @(posedge clk);
    scheme <= 1'b0;
  endtask
  task automatic t_clr();
    for (int k = 0; k < 2; k++) begin
      rd(12'h001, 32'h0000_f0f0);
      if (k == 0) lclr <= 1'b1;
      else gclr <= 1'b1;
      @(negedge clk) chk(rdat, 32'h0000_0000);
      @(posedge clk);
      lclr <= 1'b0;
      gclr <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk) chk(rdat, 32'h0000_0000);
      @(posedge clk);
    end
    rd(12'h001, 32'h0000_f0f0);
  endtask
  task automatic t_dual();
    comb <= 2'h3;
    fork
      u_user.op(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 12'h006, 12'h007,
                32'h0000_0066);
      begin
        @(posedge clk);
        @(negedge clk) chk(32'(lost), 32'h0000_0001);
      end
    join
    @(negedge clk) chk(32'(lost), 32'h0000_0000);
    @(posedge clk);
    ard <= 1'b1;
    u_user.op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 12'h006, 12'h000, '0);
    @(negedge clk) chk(32'(ardat), 32'h0000_0066);
    @(posedge clk);
    u_user.op(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 12'h000, 12'h008,
              32'h0000_0099);
    u_user.op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 12'h008, 12'h000, '0);
    @(negedge clk) chk(32'(ardat), 32'h0000_0099);
    @(posedge clk);
    ard <= 1'b0;
    comb <= 2'h0;
  endtask
  initial begin
    {rst, ce, dual, scheme, rom, lclr, gclr} = 7'h70;
    {shape, comb, sel} = 10'h000;
    ard = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk) chk(rdat, 32'h0000_0000);
    @(posedge clk);
    t_rom();
    t_shapes();
    t_combine();
    t_regs();
    t_ce();
    t_ports();
    t_clr();
    t_dual();
    report_and_stop();
  end
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule
bind cdpr_top cdpr_top_asserts u_chk (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_ce(i_ce), .i_shape(i_shape),
  .i_combine(i_combine), .i_dual_port(i_dual_port),
  .i_reg_sel(i_reg_sel), .i_local_clr(i_local_clr),
  .i_global_clr(i_global_clr), .i_wr_tick(i_wr_tick),
  .i_wr_en(i_wr_en), .i_rd_tick(i_rd_tick), .i_b_wr_en(i_b_wr_en),
  .o_rd_data(o_rd_data), .o_a_rd_data(o_a_rd_data),
  .o_b_wr_lost(o_b_wr_lost));
`default_nettype wire
